// [gpio_mux_pkg.sv]
// shared constants, register layout and state types for the gpio pin mux
package gpio_mux_pkg;

  localparam int SUBSYS_N = 4;
  localparam int PINS_PER = 4;
  localparam int PIN_N    = 16;
  localparam int SYNC_W   = 17;
  localparam int ADDR_W   = 8;

  // byte addresses: subsystem block base + register offset
  localparam logic [7:0] SUB_STRIDE   = 8'h10;
  localparam logic [7:0] OFS_GPIO     = 8'h00;
  localparam logic [7:0] OFS_WDOG     = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_EMU_CFG  = 8'h40;
  localparam logic [7:0] SUB_SPAN     = 8'h40;

  // field positions
  localparam int GPIO_VAL_LSB  = 0;
  localparam int GPIO_DIR_LSB  = 4;
  localparam int GPIO_FLAG_BIT = 8;
  localparam int GPIO_BIO_BIT  = 9;
  localparam int GPIO_TMR_BIT  = 10;
  localparam int GPIO_W        = 11;
  localparam int WDOG_EN_BIT   = 0;
  localparam int STAT_BRANCH   = 4;
  localparam int STAT_OFF      = 5;
  localparam int EMU_OFF_BIT   = 0;

  // pin positions inside a subsystem
  localparam int PIN_FLAG = 0;
  localparam int PIN_BIO  = 1;
  localparam int PIN_WDOG = 2;
  localparam int PIN_TMR  = 3;

  // reset values
  localparam logic [10:0] GPIO_RESET  = 11'h000;
  localparam logic        WDOG_RESET  = 1'b0;
  localparam logic        EMU_RESET   = 1'b0;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic       tmrSel;
    logic       bioSel;
    logic       flagSel;
    logic [3:0] dir;
    logic [3:0] outVal;
  } gpio_ctrl_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } rd_state_t;

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] stable;
  } sync_state_t;

  typedef struct packed {
    wr_state_t             wrState;
    rd_state_t             rdState;
    logic                  awHave;
    logic                  wHave;
    logic [ADDR_W-1:0]     awAddr;
    logic [31:0]           wData;
    logic [3:0]            wStrb;
    logic [1:0]            bResp;
    logic [31:0]           rData;
    logic [1:0]            rResp;
    gpio_ctrl_t [3:0]      gpio;
    logic [3:0]            wdEnable;
    logic                  emuOffCfg;
    logic [PIN_N-1:0]      pinOut;
    logic [PIN_N-1:0]      pinOe;
  } top_state_t;

endpackage

// [pin_sync.sv]
// two-flop synchroniser for the pad inputs
`timescale 1ns/100ps
module pin_sync (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          resetn,
  // raw and synchronised levels
  input  wire logic [gpio_mux_pkg::SYNC_W-1:0] rawIn,
  output logic      [gpio_mux_pkg::SYNC_W-1:0] syncOut
);

  gpio_mux_pkg::sync_state_t state_reg;
  gpio_mux_pkg::sync_state_t state_next;

  always_comb begin
    state_next        = state_reg;
    state_next.meta   = rawIn;
    state_next.stable = state_reg.meta;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign syncOut = state_reg.stable;

endmodule

// [subsys_pin_mux.sv]
// per-subsystem selection between gpio and dedicated pin functions
`timescale 1ns/100ps
module subsys_pin_mux (
  // control
  input  wire logic                     ctrl_flag,
  input  wire gpio_mux_pkg::gpio_ctrl_t ctrl,
  input  wire logic                     wdEnable,
  input  wire logic                     offActive,
  // dedicated functions of the subsystem
  input  wire logic                     externalFlagOut,
  input  wire logic                     watchdogPinOut,
  input  wire logic                     timerPinOut,
  output logic                          branchCondIn,
  // pad side
  input  wire logic [3:0]               pinSync,
  output logic      [3:0]               pinOutNext,
  output logic      [3:0]               pinOeNext,
  output logic      [3:0]               readBack
);

  logic [3:0] fnSel;
  logic [3:0] fnIsIn;
  logic [3:0] fnVal;

  // pin0 flag, pin1 branch input, pin2 watchdog, pin3 timer
  assign fnSel[gpio_mux_pkg::PIN_FLAG]  = ctrl.flagSel;
  assign fnSel[gpio_mux_pkg::PIN_BIO]   = ctrl.bioSel;
  assign fnSel[gpio_mux_pkg::PIN_WDOG]  = wdEnable;
  assign fnSel[gpio_mux_pkg::PIN_TMR]   = ctrl.tmrSel;
  assign fnIsIn = 4'h2;
  assign fnVal  = {timerPinOut, watchdogPinOut, 1'b0, externalFlagOut};

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_pin
      always_comb begin
        if (fnSel[i]) begin
          pinOutNext[i] = fnVal[i];
          pinOeNext[i]  = ~fnIsIn[i] & ~offActive;
        end else begin
          pinOutNext[i] = ctrl.outVal[i];
          pinOeNext[i]  = ctrl.dir[i] & ~offActive;
        end
        // gp inputs show the pad, everything else the latched value
        if (!fnSel[i] && !ctrl.dir[i]) begin
          readBack[i] = pinSync[i];
        end else begin
          readBack[i] = ctrl.outVal[i];
        end
      end
    end
  endgenerate

  // branch input reads the pad only while routed in
  assign branchCondIn = ctrl.bioSel & pinSync[gpio_mux_pkg::PIN_BIO] & ctrl_flag;

endmodule

// [subsystem_gpio_pin_mux.sv]
// four-subsystem gpio pin multiplexer with an axi4-lite register slave
//
// How it works
// - flag select drives external flag on pin0
// - branch select routes pin1 into branch input
// - watchdog enable puts watchdog on pin2
// - timer select drives timer output on pin3
// - written output values drive gpio output pins
// - reads return sampled gpio input pin states
// - per-pin direction bit picks input or output
// - emulation off pin low floats all pins
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
module subsystem_gpio_pin_mux (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // axi4-lite write address
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  // axi4-lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi4-lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read address
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  // axi4-lite read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // dedicated functions, one bit per subsystem
  input  wire logic [3:0]  externalFlagOut,
  input  wire logic [3:0]  watchdogPinOut,
  input  wire logic [3:0]  timerPinOut,
  output logic      [3:0]  branchCondIn,
  // emulation output-disable pin
  input  wire logic        emulationDisablePin,
  // pads, four per subsystem, subsystem s at [4s+3:4s]
  input  wire logic [15:0] gpPinIn,
  output logic      [15:0] gpPinOut,
  output logic      [15:0] gpPinOe
);

  gpio_mux_pkg::top_state_t state_reg;
  gpio_mux_pkg::top_state_t state_next;

  logic [gpio_mux_pkg::SYNC_W-1:0] syncAll;
  logic [15:0]                     pinSync;
  logic                            emuSync;
  logic                            offActive;
  logic [15:0]                     pinOutNext;
  logic [15:0]                     pinOeNext;
  logic [15:0]                     readBack;
  logic [3:0]                      branchAll;

  // pads and the emulation pin pass two flops before use
  pin_sync u_sync (
    .clk     (clk),
    .resetn  (resetn),
    .rawIn   ({emulationDisablePin, gpPinIn}),
    .syncOut (syncAll)
  );

  assign pinSync   = syncAll[15:0];
  assign emuSync   = syncAll[16];
  // float only while the pin works as output disable and is low
  assign offActive = state_reg.emuOffCfg & ~emuSync;

  genvar s;
  generate
    for (s = 0; s < gpio_mux_pkg::SUBSYS_N; s++) begin : g_sub
      subsys_pin_mux u_mux (
        .ctrl_flag       (1'b1),
        .ctrl            (state_reg.gpio[s]),
        .wdEnable        (state_reg.wdEnable[s]),
        .offActive       (offActive),
        .externalFlagOut (externalFlagOut[s]),
        .watchdogPinOut  (watchdogPinOut[s]),
        .timerPinOut     (timerPinOut[s]),
        .branchCondIn    (branchAll[s]),
        .pinSync         (pinSync[4*s+3:4*s]),
        .pinOutNext      (pinOutNext[4*s+3:4*s]),
        .pinOeNext       (pinOeNext[4*s+3:4*s]),
        .readBack        (readBack[4*s+3:4*s])
      );
    end
  endgenerate

  // byte-lane merge for partial writes
  function automatic logic [31:0] lane_merge(
    input logic [31:0] oldWord,
    input logic [31:0] newWord,
    input logic [3:0]  strb
  );
    logic [31:0] mask;
    mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (oldWord & ~mask) | (newWord & mask);
  endfunction

  // register read mux; unmapped addresses answer slverr
  function automatic logic [33:0] read_word(
    input gpio_mux_pkg::top_state_t st,
    input logic [7:0]  addr,
    input logic [15:0] rb,
    input logic [15:0] raw,
    input logic [3:0]  br,
    input logic        off
  );
    logic [31:0] word;
    logic [1:0]  resp;
    logic [1:0]  sub;
    logic [7:0]  ofs;
    word = 32'h0000_0000;
    resp = gpio_mux_pkg::RESP_OKAY;
    sub  = addr[5:4];
    ofs  = addr & (gpio_mux_pkg::SUB_STRIDE - 8'h01);
    if (addr == gpio_mux_pkg::OFS_EMU_CFG) begin
      word[gpio_mux_pkg::EMU_OFF_BIT] = st.emuOffCfg;
    end else if (addr >= gpio_mux_pkg::SUB_SPAN) begin
      resp = gpio_mux_pkg::RESP_SLVERR;
    end else if (ofs == gpio_mux_pkg::OFS_GPIO) begin
      word[gpio_mux_pkg::GPIO_W-1:0] = st.gpio[sub];
      word[gpio_mux_pkg::GPIO_DIR_LSB-1:gpio_mux_pkg::GPIO_VAL_LSB] =
        rb[4*sub +: 4];
    end else if (ofs == gpio_mux_pkg::OFS_WDOG) begin
      word[gpio_mux_pkg::WDOG_EN_BIT] = st.wdEnable[sub];
    end else if (ofs == gpio_mux_pkg::OFS_STATUS) begin
      word[3:0]                       = raw[4*sub +: 4];
      word[gpio_mux_pkg::STAT_BRANCH] = br[sub];
      word[gpio_mux_pkg::STAT_OFF]    = off;
    end else begin
      resp = gpio_mux_pkg::RESP_SLVERR;
    end
    return {resp, word};
  endfunction

  logic [31:0] curWord;
  logic [31:0] newWord;
  logic [1:0]  wrSub;
  logic [7:0]  wrOfs;
  logic [33:0] rdResult;

  always_comb begin
    state_next = state_reg;
    curWord    = 32'h0000_0000;
    newWord    = 32'h0000_0000;
    wrSub      = state_reg.awAddr[5:4];
    wrOfs      = state_reg.awAddr & (gpio_mux_pkg::SUB_STRIDE - 8'h01);
    rdResult   = read_word(state_reg, araddr, readBack, pinSync,
                           branchAll, offActive);

    // pad drivers are registered copies of the mux result
    state_next.pinOut = pinOutNext;
    state_next.pinOe  = pinOeNext;

    // write channel: address and data taken in either order
    case (state_reg.wrState)
      gpio_mux_pkg::WR_IDLE: begin
        if (awvalid && !state_reg.awHave) begin
          state_next.awHave = 1'b1;
          state_next.awAddr = awaddr;
        end
        if (wvalid && !state_reg.wHave) begin
          state_next.wHave = 1'b1;
          state_next.wData = wdata;
          state_next.wStrb = wstrb;
        end
        if (state_reg.awHave && state_reg.wHave) begin
          state_next.awHave  = 1'b0;
          state_next.wHave   = 1'b0;
          state_next.bResp   = gpio_mux_pkg::RESP_OKAY;
          state_next.wrState = gpio_mux_pkg::WR_RESP;
          if (state_reg.awAddr == gpio_mux_pkg::OFS_EMU_CFG) begin
            curWord = {31'h0, state_reg.emuOffCfg};
            newWord = lane_merge(curWord, state_reg.wData,
                                 state_reg.wStrb);
            state_next.emuOffCfg = newWord[gpio_mux_pkg::EMU_OFF_BIT];
          end else if (state_reg.awAddr >= gpio_mux_pkg::SUB_SPAN) begin
            state_next.bResp = gpio_mux_pkg::RESP_SLVERR;
          end else if (wrOfs == gpio_mux_pkg::OFS_GPIO) begin
            curWord = {21'h0, state_reg.gpio[wrSub]};
            newWord = lane_merge(curWord, state_reg.wData,
                                 state_reg.wStrb);
            // latches output values, directions and selects
            state_next.gpio[wrSub] =
              newWord[gpio_mux_pkg::GPIO_W-1:0];
          end else if (wrOfs == gpio_mux_pkg::OFS_WDOG) begin
            curWord = {31'h0, state_reg.wdEnable[wrSub]};
            newWord = lane_merge(curWord, state_reg.wData,
                                 state_reg.wStrb);
            state_next.wdEnable[wrSub] =
              newWord[gpio_mux_pkg::WDOG_EN_BIT];
          end else if (wrOfs == gpio_mux_pkg::OFS_STATUS) begin
            // status is read only; write is accepted and dropped
            state_next.bResp = gpio_mux_pkg::RESP_OKAY;
          end else begin
            state_next.bResp = gpio_mux_pkg::RESP_SLVERR;
          end
        end
      end
      gpio_mux_pkg::WR_RESP: begin
        if (bready) begin
          state_next.wrState = gpio_mux_pkg::WR_IDLE;
        end
      end
      default: begin
        state_next.wrState = gpio_mux_pkg::WR_IDLE;
      end
    endcase

    // read channel: one read at a time, data held until taken
    case (state_reg.rdState)
      gpio_mux_pkg::RD_IDLE: begin
        if (arvalid) begin
          state_next.rResp   = rdResult[33:32];
          state_next.rData   = rdResult[31:0];
          state_next.rdState = gpio_mux_pkg::RD_DATA;
        end
      end
      gpio_mux_pkg::RD_DATA: begin
        if (rready) begin
          state_next.rdState = gpio_mux_pkg::RD_IDLE;
        end
      end
      default: begin
        state_next.rdState = gpio_mux_pkg::RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg.wrState   <= gpio_mux_pkg::WR_IDLE;
      state_reg.rdState   <= gpio_mux_pkg::RD_IDLE;
      state_reg.awHave    <= 1'b0;
      state_reg.wHave     <= 1'b0;
      state_reg.awAddr    <= 8'h00;
      state_reg.wData     <= 32'h0000_0000;
      state_reg.wStrb     <= 4'h0;
      state_reg.bResp     <= gpio_mux_pkg::RESP_OKAY;
      state_reg.rData     <= 32'h0000_0000;
      state_reg.rResp     <= gpio_mux_pkg::RESP_OKAY;
      state_reg.gpio      <= {4{gpio_mux_pkg::GPIO_RESET}};
      state_reg.wdEnable  <= {4{gpio_mux_pkg::WDOG_RESET}};
      state_reg.emuOffCfg <= gpio_mux_pkg::EMU_RESET;
      state_reg.pinOut    <= 16'h0000;
      state_reg.pinOe     <= 16'h0000;
    end else begin
      state_reg <= state_next;
    end
  end

  // handshakes
  assign awready = (state_reg.wrState == gpio_mux_pkg::WR_IDLE) &
                   ~state_reg.awHave;
  assign wready  = (state_reg.wrState == gpio_mux_pkg::WR_IDLE) &
                   ~state_reg.wHave;
  assign bvalid  = (state_reg.wrState == gpio_mux_pkg::WR_RESP);
  assign bresp   = state_reg.bResp;
  assign arready = (state_reg.rdState == gpio_mux_pkg::RD_IDLE);
  assign rvalid  = (state_reg.rdState == gpio_mux_pkg::RD_DATA);
  assign rdata   = state_reg.rData;
  assign rresp   = state_reg.rResp;

  // pads and branch inputs
  assign gpPinOut     = state_reg.pinOut;
  assign gpPinOe      = state_reg.pinOe;
  assign branchCondIn = branchAll;

endmodule

// [gpio_mux_assertions.sv]
// port-level assertions for the gpio pin mux
`timescale 1ns/100ps
module gpio_mux_assertions (
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // register bus
  input wire logic [7:0]  awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  // pins
  input wire logic [3:0]  branchCondIn,
  input wire logic        emulationDisablePin,
  input wire logic [15:0] gpPinOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [7:0] wAddr_reg;
  logic       wBit_reg;
  logic       emuOn_reg;
  // shadow of the off-function enable, set late and cleared early
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wAddr_reg <= 8'h00;
      wBit_reg  <= 1'b0;
      emuOn_reg <= 1'b0;
    end else begin
      if (awvalid && awready)
        wAddr_reg <= awaddr;
      if (wvalid && wready)
        wBit_reg <= wdata[0];
      if (awvalid && awready && awaddr == gpio_mux_pkg::OFS_EMU_CFG)
        emuOn_reg <= 1'b0;
      else if (bvalid && bready && wAddr_reg == gpio_mux_pkg::OFS_EMU_CFG)
        emuOn_reg <= wBit_reg;
    end
  end
  a_write_answer:
    assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response not on time");
  a_bresp_hold:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_write_block:
    assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  a_read_answer:
    assert property (arvalid && arready |=> rvalid)
    else $error("read data not on time");
  a_rdata_hold:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_read_block:
    assert property (rvalid |-> !arready)
    else $error("read taken while data pending");
  a_read_unmapped:
    assert property (arvalid && arready && (araddr >= 8'h44 ||
      (araddr < 8'h40 && araddr[3:0] == 4'hc)) |=> rresp == 2'b10)
    else $error("unmapped read not refused");
  a_branch_input:
    assert property (({gpPinOe[13], gpPinOe[9], gpPinOe[5], gpPinOe[1]}
      & branchCondIn & $past(branchCondIn)) == 4'h0)
    else $error("branch pin still driven");
  a_emu_float:
    assert property ((emuOn_reg && !emulationDisablePin) [*3]
      |=> gpPinOe == 16'h0000)
    else $error("pads driven while off");
endmodule
bind subsystem_gpio_pin_mux gpio_mux_assertions chk (
  .clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wvalid,
  .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
  .rdata, .rresp, .rvalid, .rready, .branchCondIn,
  .emulationDisablePin, .gpPinOe
);

// [board_pin_model.sv]
// board-side model of the sixteen gpio pads
`timescale 1ns/100ps
module board_pin_model (
  // clock
  input  wire logic        clk,
  // device side
  input  wire logic [15:0] gpPinOut,
  input  wire logic [15:0] gpPinOe,
  // board drivers
  input  wire logic [15:0] extLevel,
  input  wire logic [15:0] extEn,
  // resolved pad level
  output logic      [15:0] gpPinIn
);
  logic [15:0] drift_reg = 16'h0000;
  // a released pad wanders, never holding its last value
  always @(posedge clk)
    drift_reg <= ~drift_reg;
  always_comb
    for (int i = 0; i < 16; i++)
      gpPinIn[i] = gpPinOe[i] ? gpPinOut[i]
                 : (extEn[i] ? extLevel[i] : drift_reg[i]);
endmodule

// [tb_subsystem_gpio_pin_mux.sv]
// self-checking bench for the four-subsystem gpio pin mux
`timescale 1ns/100ps
module tb_subsystem_gpio_pin_mux;
  logic        clk = 0, resetn = 0, offOn = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd, rnd = 32'hb8b93016;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  logic [3:0]  externalFlagOut = 0, watchdogPinOut = 0, timerPinOut = 0;
  logic [3:0]  branchCondIn;
  logic [3:0]  wstrb = 4'hf;
  logic        emulationDisablePin = 1;
  logic [15:0] extLevel = 0, gpPinIn, gpPinOut, gpPinOe;
  logic [3:0]  gDir [4] = '{default: 4'h0};
  logic [3:0]  gVal [4] = '{default: 4'h0};
  logic [3:0]  gSel [4] = '{default: 4'h0}; // {tmr, wdog, branch, flag}
  int          s, n_mismatch = 0, n_compared = 0;
  always #20 clk = ~clk;
  subsystem_gpio_pin_mux dut (
    .clk, .resetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .externalFlagOut, .watchdogPinOut, .timerPinOut, .branchCondIn,
    .emulationDisablePin, .gpPinIn, .gpPinOut, .gpPinOe
  );
  board_pin_model pads (
    .clk, .gpPinOut, .gpPinOe, .extLevel, .extEn(16'hffff), .gpPinIn
  );
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [3:0] expOe(input int k);
    logic [3:0] f;
    f = gSel[k];
    return offOn ? 4'h0 : ((gDir[k] & ~f) | {f[3], f[2], 1'b0, f[0]});
  endfunction
  function automatic logic [3:0] expOut(input int k);
    return {gSel[k][3] ? timerPinOut[k] : gVal[k][3],
            gSel[k][2] ? watchdogPinOut[k] : gVal[k][2], gVal[k][1],
            gSel[k][0] ? externalFlagOut[k] : gVal[k][0]};
  endfunction
  task automatic check(input string what, input logic [31:0] e,
                       input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic timeout();
    n_mismatch++;
    tally_and_finish();
  endtask
  task automatic checkPads();
    for (int k = 0; k < 4; k++) begin
      check("pad enable", expOe(k), gpPinOe[4*k +: 4]);
      check("pad level", expOut(k) & expOe(k),
            gpPinOut[4*k +: 4] & gpPinOe[4*k +: 4]);
      check("branch", gSel[k][1] & extLevel[4*k+1], branchCondIn[k]);
    end
  endtask
  // handshakes are judged mid-cycle, acted on at the next rising edge
  task automatic axWrite(input logic [7:0] a, input logic [31:0] d);
    logic tA, tW, tB;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      tA = awvalid && awready;
      tW = wvalid && wready;
      tB = bvalid && bready;
      resp = bresp;
      @(posedge clk);
      if (tA)
        awvalid <= 1'b0;
      if (tW)
        wvalid <= 1'b0;
      if (tB) begin
        bready <= 1'b0;
        return;
      end
    end
    timeout();
  endtask
  task automatic axRead(input logic [7:0] a);
    logic tA, tR;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      tA = arvalid && arready;
      tR = rvalid && rready;
      rd = rdata;
      resp = rresp;
      @(posedge clk);
      if (tA)
        arvalid <= 1'b0;
      if (tR) begin
        rready <= 1'b0;
        return;
      end
    end
    timeout();
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
    checkPads();
  endtask
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      axRead(8'(16 * k + 4));
      check("wdog reset", 32'h0, rd);
    end
    axRead(8'h40);
    check("emu reset", 32'h0, rd);
    for (int k = 0; k < 12; k++) begin
      s = k % 4;
      rnd = lfsr(rnd);
      gDir[s] = k < 4 ? 4'hf : (k < 8 ? 4'h0 : rnd[7:4]);
      gVal[s] = rnd[3:0];
      extLevel <= rnd[31:16];
      axWrite(8'(16 * s), {24'h0, gDir[s], gVal[s]});
      repeat (3) @(posedge clk);
      checkPads();
      axRead(8'(16 * s));
      check("gpio read", {24'h0, gDir[s], (gDir[s] & gVal[s]) |
            (~gDir[s] & extLevel[4*s +: 4])}, rd);
    end
    for (int k = 0; k < 8; k++) begin
      s = k % 4;
      rnd = lfsr(rnd);
      gSel[s] = k < 4 ? 4'hf : rnd[11:8];
      gDir[s] = rnd[7:4];
      gVal[s] = rnd[3:0];
      axWrite(8'(16 * s), {21'h0, gSel[s][3], gSel[s][1:0], gDir[s],
              gVal[s]});
      axWrite(8'(16 * s + 4), {31'h0, gSel[s][2]});
      for (int j = 0; j < 2; j++) begin
        rnd = lfsr(rnd);
        {externalFlagOut, watchdogPinOut, timerPinOut} <= rnd[11:0];
        extLevel <= rnd[31:16];
        repeat (3) @(posedge clk);
        checkPads();
      end
    end
    // low byte lane only: selects must survive the write
    wstrb <= 4'h1;
    axWrite(8'h00, 32'h0000_07ff);
    wstrb <= 4'hf;
    gDir[0] = 4'hf;
    gVal[0] = 4'hf;
    axRead(8'h00);
    check("gpio lanes", {21'h0, gSel[0][3], gSel[0][1:0], 8'hff},
          rd);
    settle();
    axWrite(8'h40, 32'h1);
    emulationDisablePin <= 1'b0;
    offOn = 1'b1;
    settle();
    axRead(8'h08);
    check("status", {26'h0, 1'b1, gSel[0][1] & extLevel[1],
          extLevel[3:0]}, rd);
    emulationDisablePin <= 1'b1;
    offOn = 1'b0;
    settle();
    axWrite(8'h40, 32'h0);
    emulationDisablePin <= 1'b0;
    settle();
    emulationDisablePin <= 1'b1;
    axRead(8'h0c);
    check("read resp", 2'b10, resp);
    axRead(8'h50);
    check("read resp", 2'b10, resp);
    axWrite(8'h2c, 32'h7ff);
    check("write resp", 2'b10, resp);
    axWrite(8'h08, 32'h7ff);
    check("write resp", 2'b00, resp);
    settle();
    tally_and_finish();
  end
endmodule
